// ===== bdmtc_bus_model.sv
// bus line model: mirrors the driven symbol or shows a remote one
`timescale 1ns/1ns
`default_nettype none
module bdmtc_bus_model
  import bdmtc_pkg::*;
(
  input  wire logic       drive_on_in, // transmitter on
  input  wire logic       sym_high_in, // driven symbol
  input  wire bdmtc_sym_t inj_in,      // remote symbol when not driving
  output logic            pos_out,     // difference above threshold
  output logic            neg_out      // difference below threshold
);
  bdmtc_sym_t sym;
  always_comb begin
    if (drive_on_in) sym = sym_high_in ? BDMTC_SYM_HIGH : BDMTC_SYM_LOW;
    else sym = inj_in;
    pos_out = (sym == BDMTC_SYM_HIGH);
    neg_out = (sym == BDMTC_SYM_LOW);
  end
endmodule : bdmtc_bus_model
`default_nettype wire

// ===== bdmtc_pkg.sv
// package of constants and types for the bus driver mode and transmit control block
// How it works
// - transmitter drives lines only in full_mode
// - transmit needs full_mode, enable low, guardian high
// - enable accepted only while transmit bit low
// - enabled transmitter forwards bit as high/low symbol
// - idle symbol means transmitter switched off
// - mode changes only by pins, undervoltage, wake
// - sleep entered through sleep_entry_step state
// - floating mode pins read low, giving standby_mode
// - floating enable or guardian keeps transmitter off
// - floating transmit bit drives bus_low_symbol
// - missing io reference forces input defaults
// - missing io reference forces rx bit low
// - low power and listen ignore transmit inputs
// - full and listen bias lines to bias_level
// - standby, sleep, entry ground lines; unpowered open
// - receiver classifies idle, high, low in full and listen only
// - receive filter sized for 60 ns bits
// - missing supply puts device in unpowered mode
// - sleep and standby are low power modes
// - overtemperature switches transmitter off
// - pin encoding selects full, listen, sleep, standby
// - guardian low disables transmitter, full_mode only
// - activity low when active, rx bit follows data
// - low power rx bit shows wake flag, low set
package bdmtc_pkg;

  typedef enum logic [2:0] {
    BDMTC_UNPOWERED,
    BDMTC_STANDBY,
    BDMTC_SLEEP_ENTRY,
    BDMTC_SLEEP,
    BDMTC_LISTEN,
    BDMTC_FULL
  } bdmtc_mode_t;

  typedef enum logic [1:0] {
    BDMTC_SYM_IDLE,
    BDMTC_SYM_LOW,
    BDMTC_SYM_HIGH
  } bdmtc_sym_t;

  typedef enum logic [1:0] {
    BDMTC_BIAS_OPEN,
    BDMTC_BIAS_GND,
    BDMTC_BIAS_LEVEL
  } bdmtc_bias_t;

  // controller-side digital inputs
  typedef struct packed {
    logic tx_bit;
    logic tx_enable_n;
    logic guardian_enable;
  } bdmtc_cc_in_t;

  // host mode pins
  typedef struct packed {
    logic standby_n_sel;
    logic mode_sel_a;
  } bdmtc_host_in_t;

  // supply and wake status
  typedef struct packed {
    logic supply_ok;
    logic io_ref_supply_ok;
    logic wake_flag;
    logic over_temp;
  } bdmtc_stat_t;

  // timing of the receive filter
  localparam int unsigned BDMTC_CLK_PERIOD_NS = 10;
  localparam int unsigned BDMTC_MIN_BIT_NS    = 60;
  // a valid symbol must be stable for at least half the shortest bit
  localparam int unsigned BDMTC_FILT_CYC      =
    ((BDMTC_MIN_BIT_NS / 2) / BDMTC_CLK_PERIOD_NS > 0) ?
    (BDMTC_MIN_BIT_NS / 2) / BDMTC_CLK_PERIOD_NS : 1;

  // reset values
  localparam bdmtc_mode_t BDMTC_RST_MODE = BDMTC_STANDBY;
  localparam bdmtc_sym_t  BDMTC_RST_SYM  = BDMTC_SYM_IDLE;
  // synchroniser contents in reset: quiet pin levels with supplies good,
  // so the first edges after release never see a false unpowered step
  localparam bdmtc_cc_in_t   BDMTC_RST_CC   = '{tx_bit: 1'b0, tx_enable_n: 1'b1,
                                                guardian_enable: 1'b0};
  localparam bdmtc_host_in_t BDMTC_RST_HOST = '{standby_n_sel: 1'b0, mode_sel_a: 1'b0};
  localparam bdmtc_stat_t    BDMTC_RST_STAT = '{supply_ok: 1'b1, io_ref_supply_ok: 1'b1,
                                                wake_flag: 1'b0, over_temp: 1'b0};
  localparam logic [1:0]     BDMTC_RST_CMP  = 2'h0;

  function automatic logic bdmtc_low_power(input bdmtc_mode_t m);
    return (m == BDMTC_STANDBY) || (m == BDMTC_SLEEP);
  endfunction : bdmtc_low_power

endpackage : bdmtc_pkg

// ===== bdmtc_rx_filter.sv
// receive symbol filter: a symbol is taken once stable for a set number of samples
`timescale 1ns/1ns
`default_nettype none
module bdmtc_rx_filter
  import bdmtc_pkg::*;
#(
  parameter int unsigned FILT_CYC = BDMTC_FILT_CYC
) (
  input  wire logic       ref_clk_in,   // sampling clock
  input  wire logic       reset_n_in,   // sync reset, low active
  input  wire bdmtc_sym_t raw_sym_in,   // comparator result, synchronised
  output bdmtc_sym_t      sym_out       // filtered symbol
);
  localparam int unsigned CW = $clog2(FILT_CYC + 1);

  typedef struct packed {
    bdmtc_sym_t    cand;
    logic [CW-1:0] cnt;
    bdmtc_sym_t    sym;
  } bdmtc_filt_st_t;

  bdmtc_filt_st_t st_ff;
  bdmtc_filt_st_t nxt_st;

  initial begin
    if (FILT_CYC < 1) $error("bdmtc_rx_filter: FILT_CYC must be at least 1");
  end

  // shorter pulses than the filter time never reach the output
  always_comb begin
    nxt_st = st_ff;
    if (raw_sym_in != st_ff.cand) begin
      nxt_st.cand = raw_sym_in;
      nxt_st.cnt  = CW'(1);
    end else if (st_ff.cnt < CW'(FILT_CYC)) begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
    if (nxt_st.cnt >= CW'(FILT_CYC)) begin
      nxt_st.sym = nxt_st.cand;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '{cand: BDMTC_RST_SYM, cnt: '0, sym: BDMTC_RST_SYM};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sym_out = st_ff.sym;

endmodule : bdmtc_rx_filter
`default_nettype wire

// ===== bdmtc_sync.sv
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
`default_nettype none
module bdmtc_sync
  import bdmtc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk_in,   // sampling clock
  input  wire logic             reset_n_in,   // sync reset, low active
  input  wire logic [WIDTH-1:0] rst_val_in,   // value held in reset
  input  wire logic [WIDTH-1:0] d_in,         // raw pins
  output logic      [WIDTH-1:0] q_out         // synchronised pins
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } bdmtc_sync_st_t;

  bdmtc_sync_st_t st_ff;
  bdmtc_sync_st_t nxt_st;

  initial begin
    if (WIDTH < 1) $error("bdmtc_sync: WIDTH must be at least 1");
  end

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
  end

  // reset loads the quiet pin levels given at the instance, so logic behind sees no false step
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '{s1: rst_val_in, s2: rst_val_in};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_out = st_ff.s2;

endmodule : bdmtc_sync
`default_nettype wire

// ===== bdmtc_top.sv
// mode control, transmit gating, bus biasing and receive reporting of the bus driver
`timescale 1ns/1ns
`default_nettype none
module bdmtc_top
  import bdmtc_pkg::*;
#(
  parameter int unsigned FILT_CYC = BDMTC_FILT_CYC
) (
  input  wire logic ref_clk_in,            // 100 MHz sampling clock
  input  wire logic reset_n_in,            // sync reset, low active
  input  wire logic tx_bit_in,             // transmit bit from controller
  input  wire logic tx_enable_n_in,        // transmit enable, low active
  input  wire logic guardian_enable_in,    // guardian enable, high active
  input  wire logic standby_n_sel_in,      // mode pin, standby not
  input  wire logic mode_sel_a_in,         // mode pin a
  input  wire logic supply_ok_in,          // battery and transmitter supplies good
  input  wire logic io_ref_supply_ok_in,   // io reference supply good
  input  wire logic wake_flag_in,          // wake-up flag from wake detector
  input  wire logic over_temp_in,          // transmitter overtemperature
  input  wire logic bus_diff_pos_in,       // comparator: difference above +threshold
  input  wire logic bus_diff_neg_in,       // comparator: difference below -threshold
  output logic      tx_drive_on_out,       // transmitter output stage on
  output logic      tx_symbol_high_out,    // 1 drives high symbol, 0 low symbol
  output logic      bias_level_sel_out,    // bus lines biased to bias_level
  output logic      bias_gnd_sel_out,      // bus lines tied to ground
  output logic      pull_struct_en_out,    // transmit input pull structures on
  output logic      rx_bit_out,            // received bit or wake flag
  output logic      rx_activity_n_out,     // bus activity, low active
  output logic [2:0] mode_out              // current mode
);

  typedef struct packed {
    bdmtc_mode_t mode;
    logic        tx_on;
    logic        tx_high;
    logic        bias_lvl;
    logic        bias_gnd;
    logic        pull_en;
    logic        rx_bit;
    logic        rx_act_n;
  } bdmtc_top_st_t;

  bdmtc_top_st_t st_ff;
  bdmtc_top_st_t nxt_st;

  bdmtc_cc_in_t   cc_raw;
  bdmtc_cc_in_t   cc_s;
  bdmtc_cc_in_t   cc_eff;
  bdmtc_host_in_t host_raw;
  bdmtc_host_in_t host_s;
  bdmtc_stat_t    stat_raw;
  bdmtc_stat_t    stat_s;
  bdmtc_sym_t     raw_sym;
  bdmtc_sym_t     sym_f;
  logic [1:0]     cmp_raw;
  logic [1:0]     cmp_s;

  localparam int unsigned SYNC_W = 3 + 2 + 4 + 2;

  initial begin
    if (FILT_CYC < 1) $error("bdmtc_top: FILT_CYC must be at least 1");
  end

  assign cc_raw   = '{tx_bit: tx_bit_in, tx_enable_n: tx_enable_n_in,
                      guardian_enable: guardian_enable_in};
  assign host_raw = '{standby_n_sel: standby_n_sel_in, mode_sel_a: mode_sel_a_in};
  assign stat_raw = '{supply_ok: supply_ok_in, io_ref_supply_ok: io_ref_supply_ok_in,
                      wake_flag: wake_flag_in, over_temp: over_temp_in};
  assign cmp_raw  = {bus_diff_pos_in, bus_diff_neg_in};

  // all pin inputs pass one synchroniser; in reset it holds quiet pin levels with supplies good
  bdmtc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .rst_val_in ({BDMTC_RST_CC, BDMTC_RST_HOST, BDMTC_RST_STAT, BDMTC_RST_CMP}),
    .d_in       ({cc_raw, host_raw, stat_raw, cmp_raw}),
    .q_out      ({cc_s, host_s, stat_s, cmp_s})
  );

  always_comb begin
    if (cmp_s == 2'b10) begin
      raw_sym = BDMTC_SYM_HIGH;
    end else if (cmp_s == 2'b01) begin
      raw_sym = BDMTC_SYM_LOW;
    end else begin
      raw_sym = BDMTC_SYM_IDLE;
    end
  end

  bdmtc_rx_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_rx_filter (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .raw_sym_in (raw_sym),
    .sym_out    (sym_f)
  );

  // missing io reference forces the documented pin defaults: bit low, enable high, guardian low
  always_comb begin
    cc_eff = cc_s;
    if (!stat_s.io_ref_supply_ok) begin
      cc_eff.tx_bit          = 1'b0;
      cc_eff.tx_enable_n     = 1'b1;
      cc_eff.guardian_enable = 1'b0;
    end
  end

  always_comb begin
    nxt_st = st_ff;

    // mode: only pins, undervoltage or the wake flag move it
    if (!stat_s.supply_ok) begin
      nxt_st.mode = BDMTC_UNPOWERED;
    end else if (!stat_s.io_ref_supply_ok) begin
      // fail-safe with no valid host levels: pins read as their pull-down defaults
      nxt_st.mode = BDMTC_STANDBY;
    end else begin
      case ({host_s.standby_n_sel, host_s.mode_sel_a})
        2'b11: nxt_st.mode = BDMTC_FULL;
        2'b10: nxt_st.mode = BDMTC_LISTEN;
        2'b01: begin
          if (st_ff.mode == BDMTC_SLEEP_ENTRY || st_ff.mode == BDMTC_SLEEP) begin
            nxt_st.mode = BDMTC_SLEEP;
          end else begin
            nxt_st.mode = BDMTC_SLEEP_ENTRY;
          end
        end
        default: nxt_st.mode = BDMTC_STANDBY;
      endcase
      // a set wake flag keeps the device out of sleep
      if (stat_s.wake_flag && (nxt_st.mode == BDMTC_SLEEP_ENTRY || nxt_st.mode == BDMTC_SLEEP))
      begin
        nxt_st.mode = BDMTC_STANDBY;
      end
    end

    // transmitter gating; activation only accepted while the bit is low
    if (st_ff.mode != BDMTC_FULL || cc_eff.tx_enable_n || !cc_eff.guardian_enable
        || stat_s.over_temp) begin
      nxt_st.tx_on = 1'b0;
    end else if (st_ff.tx_on) begin
      nxt_st.tx_on = 1'b1;
    end else begin
      nxt_st.tx_on = !cc_eff.tx_bit;
    end
    // pull-down on a floating bit gives the low symbol
    nxt_st.tx_high = nxt_st.tx_on && cc_eff.tx_bit;

    // pulls follow the mode; listen and low power turn them off
    nxt_st.pull_en = (st_ff.mode == BDMTC_FULL);

    // bus biasing
    case (st_ff.mode)
      BDMTC_FULL, BDMTC_LISTEN: begin
        nxt_st.bias_lvl = 1'b1;
        nxt_st.bias_gnd = 1'b0;
      end
      BDMTC_STANDBY, BDMTC_SLEEP_ENTRY, BDMTC_SLEEP: begin
        nxt_st.bias_lvl = 1'b0;
        nxt_st.bias_gnd = 1'b1;
      end
      default: begin
        nxt_st.bias_lvl = 1'b0;
        nxt_st.bias_gnd = 1'b0;
      end
    endcase

    // receive reporting
    if (!stat_s.io_ref_supply_ok) begin
      nxt_st.rx_bit   = 1'b0;
      nxt_st.rx_act_n = 1'b0;
    end else if (bdmtc_low_power(st_ff.mode) || st_ff.mode == BDMTC_SLEEP_ENTRY
                 || st_ff.mode == BDMTC_UNPOWERED) begin
      nxt_st.rx_bit   = !stat_s.wake_flag;
      nxt_st.rx_act_n = !stat_s.wake_flag;
    end else begin
      nxt_st.rx_bit   = (sym_f != BDMTC_SYM_LOW);
      nxt_st.rx_act_n = (sym_f == BDMTC_SYM_IDLE);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '{mode: BDMTC_RST_MODE, tx_on: 1'b0, tx_high: 1'b0, bias_lvl: 1'b0,
                 bias_gnd: 1'b1, pull_en: 1'b0, rx_bit: 1'b1, rx_act_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tx_drive_on_out    = st_ff.tx_on;
  assign tx_symbol_high_out = st_ff.tx_high;
  assign bias_level_sel_out = st_ff.bias_lvl;
  assign bias_gnd_sel_out   = st_ff.bias_gnd;
  assign pull_struct_en_out = st_ff.pull_en;
  assign rx_bit_out         = st_ff.rx_bit;
  assign rx_activity_n_out  = st_ff.rx_act_n;
  assign mode_out           = st_ff.mode;

endmodule : bdmtc_top
`default_nettype wire

// ===== bdmtc_top_asserts.sv
// concurrent checks on the ports of the bus driver control block
`timescale 1ns/1ns
`default_nettype none
module bdmtc_top_asserts
  import bdmtc_pkg::*;
#(
  parameter int unsigned FILT_CYC = BDMTC_FILT_CYC
) (
  input wire logic       ref_clk_in,          // clock
  input wire logic       reset_n_in,          // reset
  input wire logic       tx_bit_in,           // tx bit
  input wire logic       tx_enable_n_in,      // tx enable
  input wire logic       guardian_enable_in,  // guardian
  input wire logic       io_ref_supply_ok_in, // io ref
  input wire logic       tx_drive_on_out,     // tx on
  input wire logic       tx_symbol_high_out,  // tx symbol
  input wire logic       bias_level_sel_out,  // bias level
  input wire logic       bias_gnd_sel_out,    // bias gnd
  input wire logic       rx_bit_out,          // rx bit
  input wire logic       rx_activity_n_out,   // rx activity
  input wire logic [2:0] mode_out             // mode
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // one cycle of slack: mode and tx may update on neighbouring edges
  tx_full_only_a: assert property (
    tx_drive_on_out |-> mode_out == 3'h5 || $past(mode_out) == 3'h5) else $error("tx outside full");
  idle_off_a: assert property (
    !tx_drive_on_out |-> !tx_symbol_high_out) else $error("symbol while off");
  start_low_a: assert property (
    $rose(tx_drive_on_out) |-> !tx_symbol_high_out) else $error("start on high");
  tx_follow_a: assert property (
    (tx_drive_on_out && $stable(tx_bit_in))[*6] |-> tx_symbol_high_out == tx_bit_in)
    else $error("symbol not bit");
  guard_off_a: assert property (
    (!guardian_enable_in)[*5] |-> !tx_drive_on_out) else $error("guardian ignored");
  enable_off_a: assert property (
    tx_enable_n_in[*5] |-> !tx_drive_on_out) else $error("enable ignored");
  bias_on_a: assert property (
    $stable(mode_out) && mode_out inside {3'h4, 3'h5} |-> bias_level_sel_out && !bias_gnd_sel_out)
    else $error("bias level wrong");
  bias_gnd_a: assert property (
    $stable(mode_out) && mode_out inside {3'h1, 3'h3} |-> bias_gnd_sel_out && !bias_level_sel_out)
    else $error("bias gnd wrong");
  sleep_step_a: assert property (
    $changed(mode_out) && mode_out == 3'h3 |-> $past(mode_out) == 3'h2) else $error("sleep skipped");
  io_rx_low_a: assert property (
    (!io_ref_supply_ok_in)[*8] |-> !rx_bit_out) else $error("rx not forced low");
  rx_idle_a: assert property (
    rx_activity_n_out |-> rx_bit_out) else $error("idle rx bit low");
endmodule : bdmtc_top_asserts
bind bdmtc_top bdmtc_top_asserts #(
  .FILT_CYC (FILT_CYC)
) u_chk (
  .ref_clk_in          (ref_clk_in),
  .reset_n_in          (reset_n_in),
  .tx_bit_in           (tx_bit_in),
  .tx_enable_n_in      (tx_enable_n_in),
  .guardian_enable_in  (guardian_enable_in),
  .io_ref_supply_ok_in (io_ref_supply_ok_in),
  .tx_drive_on_out     (tx_drive_on_out),
  .tx_symbol_high_out  (tx_symbol_high_out),
  .bias_level_sel_out  (bias_level_sel_out),
  .bias_gnd_sel_out    (bias_gnd_sel_out),
  .rx_bit_out          (rx_bit_out),
  .rx_activity_n_out   (rx_activity_n_out),
  .mode_out            (mode_out)
);
`default_nettype wire

// ===== tb.sv
// self-checking bench for the bus driver mode and transmit control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bdmtc_pkg::*;
  logic       ref_clk_in, reset_n_in, sb, ma, txb, ten, ge, sup, io, wk, ot;
  logic       ton, thi, bl, bg, pe, rb, ra, pos, neg;
  logic [2:0] md;
  bdmtc_sym_t inj;
  int         n_errors, samples_checked;
  logic [7:0] mexp [4] = '{8'h5, 8'h4, 8'h3, 8'h1};

  bdmtc_top dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .tx_bit_in(txb),
    .tx_enable_n_in(ten), .guardian_enable_in(ge), .standby_n_sel_in(sb), .mode_sel_a_in(ma),
    .supply_ok_in(sup), .io_ref_supply_ok_in(io), .wake_flag_in(wk), .over_temp_in(ot),
    .bus_diff_pos_in(pos), .bus_diff_neg_in(neg), .tx_drive_on_out(ton),
    .tx_symbol_high_out(thi), .bias_level_sel_out(bl), .bias_gnd_sel_out(bg),
    .pull_struct_en_out(pe), .rx_bit_out(rb), .rx_activity_n_out(ra), .mode_out(md));
  bdmtc_bus_model u_bus (.drive_on_in(ton), .sym_high_in(thi), .inj_in(inj),
    .pos_out(pos), .neg_out(neg));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // outputs stand as levels, so a settled wait longer than any latency is safe
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wait_cyc

  task automatic pins(input logic [4:0] v);
    @(posedge ref_clk_in);
    {sb, ma, txb, ten, ge} <= v;
    wait_cyc(12);
  endtask : pins

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (3000) @(posedge ref_clk_in);
    n_errors++;
    final_report();
  end

  initial begin
    {sb, ma, txb, ten, ge, sup, io, wk, ot} = 9'h02c;
    inj = BDMTC_SYM_IDLE;
    n_errors = 0;
    samples_checked = 0;
    reset_n_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    wait_cyc(1);
    chk("rst", {ton, thi, bl, bg, rb, ra}, 8'h07);
    chk("rst mode", md, 8'h1);
    wait_cyc(10);
    chk("mode", md, 8'h1);
    for (int i = 0; i < 4; i++) begin
      pins({2'(3 - i), 3'b010});
      chk("mode", md, mexp[i]);
      chk("bias", {bl, bg}, (i < 2) ? 8'h2 : 8'h1);
      chk("pulls", pe, 8'(i == 0));
    end
    pins(5'b10001);
    chk("listen", {ton, pe}, 8'h0);
    $display("test modes done");
    pins(5'b11101);
    chk("tx", ton, 8'h0);
    pins(5'b11001);
    chk("tx", {ton, thi}, 8'h2);
    chk("rx", {rb, ra}, 8'h0);
    pins(5'b11101);
    chk("tx", {ton, thi}, 8'h3);
    chk("rx", {rb, ra}, 8'h2);
    pins(5'b11100);
    chk("tx", {ton, thi}, 8'h0);
    pins(5'b11011);
    chk("tx", ton, 8'h0);
    pins(5'b11001);
    @(posedge ref_clk_in);
    ot <= 1'b1;
    wait_cyc(12);
    chk("tx", ton, 8'h0);
    ot <= 1'b0;
    io <= 1'b0;
    wait_cyc(12);
    chk("io", {ton, rb, md}, 8'h01);
    io <= 1'b1;
    $display("test transmit done");
    pins(5'b11011);
    inj <= BDMTC_SYM_HIGH;
    wait_cyc(12);
    chk("rx", {rb, ra}, 8'h2);
    inj <= BDMTC_SYM_LOW;
    wait_cyc(12);
    chk("rx", {rb, ra}, 8'h0);
    inj <= BDMTC_SYM_IDLE;
    wait_cyc(12);
    inj <= BDMTC_SYM_HIGH;
    @(posedge ref_clk_in);
    inj <= BDMTC_SYM_IDLE;
    for (int i = 0; i < 10; i++) begin
      wait_cyc(1);
      chk("glitch", {rb, ra}, 8'h3);
    end
    $display("test receive done");
    pins(5'b00010);
    wk <= 1'b1;
    wait_cyc(12);
    chk("wake", {rb, ra}, 8'h0);
    pins(5'b01010);
    chk("mode", md, 8'h1);
    wk <= 1'b0;
    wait_cyc(12);
    chk("wake", {rb, ra}, 8'h3);
    sup <= 1'b0;
    wait_cyc(12);
    chk("off", {md, bl, bg}, 8'h0);
    sup <= 1'b1;
    $display("test power done");
    final_report();
  end
endmodule : tb
`default_nettype wire
